// ### logic/cache_maintenance_op_unit.sv
// Cache maintenance operation unit: address formation, cache selection,
// tag operations, writeback and fill, and the exception decision.
// Assumes the pipeline holds the base register value with the instruction,
// an MMU with a request/acknowledge port, and a bus that acknowledges once.
`timescale 1ns/100ps

// Operation
// R1: Address is base register value plus sign-extended 16-bit displacement.
// R2: Selector sits in bits 20..16, displacement 15..0, base above selector.
// R3: Address operations index the cache directly; translation is optional.
// R4: Index operations are translated; indexing address is selectable, no tag match.
// R5: Offset, index and way fields derive from cache geometry.
// R6: Direct-mapped cache ignores the way field.
// R7: Translation faults report the load-type translation cause.
// R8: Never a modified fault nor store-type translation cause.
// R9: Never execute-inhibit or read-inhibit faults.
// R10: Any alignment accepted; no unaligned address error.
// R11: Cache or bus error during writeback raises cache error.
// R12: Bus error on a fill raises bus error.
// R13: Index load and store tag never raise cache error.
// R14: Optional kernel region check raises load-type address error.
// R15: Watch match behaviour is fixed by one control bit.
// R16: Earlier memory work drains first; done only after bus completion.
// R17: Target cache comes from bits 17..16.
// R18: Selector codes: instruction, data, tertiary, secondary.
// R19: Operation comes from bits 20..18.
// R20: A fault leaves cache and memory unchanged and reports precisely.
module cache_maintenance_op_unit #(
    parameter int CACHE_BYTES   = 4096,
    parameter int ASSOC         = 2,
    parameter int BYTES_PER_TAG = 16,
    parameter int APB_AW        = 8
) (
    // Clock and reset.
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Instruction issue from the pipeline.
    input  wire logic                  issue_valid,
    input  wire cmo_pkg::issue_type    issue,
    output logic                       issue_ready,
    input  wire logic                  user_mode,
    output cmo_pkg::report_type        report,
    // Translation port.
    output logic                       mmu_req,
    output logic [31:0]                mmu_vaddr,
    input  wire logic                  mmu_ack,
    input  wire cmo_pkg::mmu_resp_type mmu_resp,
    // Memory bus and ordering.
    input  wire logic                  mem_idle,
    output logic                       bus_req,
    output logic                       bus_write,
    output logic [31:0]                bus_addr,
    input  wire logic                  bus_ack,
    input  wire logic                  bus_err,
    // APB register port.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [APB_AW-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr
);

    // Geometry of one cache.
    localparam int line_offset_width = $clog2(BYTES_PER_TAG);
    localparam int set_index_top     = $clog2(CACHE_BYTES / ASSOC);
    localparam int way_field_top     = set_index_top + $clog2(ASSOC);
    localparam int IDX_W             = set_index_top - line_offset_width;
    localparam int WAY_W             = (ASSOC > 1) ? $clog2(ASSOC) : 1;
    localparam int TAG_W             = 32 - set_index_top;
    localparam int MEM_AW            = 2 + WAY_W + IDX_W;
    localparam logic [WAY_W-1:0] LAST_WAY = WAY_W'(ASSOC - 1);

    typedef struct packed {
        logic             par;
        logic             valid;
        logic             dirty;
        logic [TAG_W-1:0] tag;
    } entry_type;

    typedef struct packed {
        cmo_pkg::state_type    st;
        logic [31:0]           ea;
        logic [31:0]           addr;
        logic [2:0]            op;
        logic [1:0]            sel;
        logic [WAY_W-1:0]      way;
        entry_type             new_e;
        logic                  bus_wr;
        logic [31:0]           bus_addr;
        cmo_pkg::exc_code_type exc;
        logic                  refill;
        cmo_pkg::report_type   rep;
        cmo_pkg::exc_code_type last_exc;
        logic [15:0]           count;
        logic [cmo_pkg::CTRL_W-1:0] ctrl;
        logic [31:0]           tag_lo;
        logic [31:0]           tag_res;
        logic [31:0]           watch;
        logic [31:0]           prdata;
    } state_type;

    state_type         s_r;
    state_type         s_nxt;
    logic [MEM_AW-1:0] mem_addr;
    logic [TAG_W+2:0]  mem_rdata;
    entry_type         rd_e;
    logic              mem_we;

    // Way field; a direct-mapped cache always uses way zero.
    function automatic logic [WAY_W-1:0] way_of(input logic [31:0] a);
        // R6: way ignored
        if (ASSOC == 1) begin
            return '0;
        end
        return a[set_index_top +: WAY_W];
    endfunction

    // R5: field split
    function automatic logic [IDX_W-1:0] index_of(input logic [31:0] a);
        return a[line_offset_width +: IDX_W];
    endfunction

    function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
        return a[set_index_top +: TAG_W];
    endfunction

    // Builds an entry with its parity bit.
    function automatic entry_type make_entry(input logic v, input logic d,
                                             input logic [TAG_W-1:0] t);
        entry_type e;
        e.valid = v;
        e.dirty = d;
        e.tag   = t;
        e.par   = ^{v, d, t};
        return e;
    endfunction

    function automatic logic reg_ok(input logic [APB_AW-1:0] a);
        return a == APB_AW'(cmo_pkg::REG_CTRL) || a == APB_AW'(cmo_pkg::REG_STATUS)
            || a == APB_AW'(cmo_pkg::REG_TAG_LO) || a == APB_AW'(cmo_pkg::REG_TAG_RESULT)
            || a == APB_AW'(cmo_pkg::REG_WATCH);
    endfunction

    // Whole state, one step ahead.
    always_comb begin
        logic [31:0] ea;
        logic        is_index;
        logic        hit;
        logic        wb_cache;
        logic        fault;
        ea       = '0;
        is_index = (s_r.op == cmo_pkg::OP_INDEX_INV) || (s_r.op == cmo_pkg::OP_LOAD_TAG)
                || (s_r.op == cmo_pkg::OP_STORE_TAG);
        hit      = rd_e.valid && (rd_e.tag == tag_of(s_r.addr));
        wb_cache = (s_r.sel != cmo_pkg::SEL_PRIM_INSTR);
        fault    = 1'b0;
        s_nxt    = s_r;
        s_nxt.rep.done = 1'b0;

        // Register port: read data latched in the setup cycle.
        if (psel && !penable) begin
            case (paddr)
                APB_AW'(cmo_pkg::REG_CTRL): begin
                    s_nxt.prdata = 32'(s_r.ctrl);
                end
                APB_AW'(cmo_pkg::REG_STATUS): begin
                    s_nxt.prdata = '0;
                    s_nxt.prdata[cmo_pkg::STAT_BUSY_BIT] = (s_r.st != cmo_pkg::ST_IDLE);
                    s_nxt.prdata[cmo_pkg::STAT_EXC_LSB +: 3] = s_r.last_exc;
                    s_nxt.prdata[cmo_pkg::STAT_COUNT_LSB +: 16] = s_r.count;
                end
                APB_AW'(cmo_pkg::REG_TAG_LO):     s_nxt.prdata = s_r.tag_lo;
                APB_AW'(cmo_pkg::REG_TAG_RESULT): s_nxt.prdata = s_r.tag_res;
                APB_AW'(cmo_pkg::REG_WATCH):      s_nxt.prdata = s_r.watch;
                default:                          s_nxt.prdata = '0;
            endcase
        end
        if (psel && penable && pwrite && reg_ok(paddr)) begin
            if (paddr == APB_AW'(cmo_pkg::REG_CTRL)) begin
                s_nxt.ctrl = pwdata[cmo_pkg::CTRL_W-1:0];
            end
            if (paddr == APB_AW'(cmo_pkg::REG_TAG_LO)) begin
                s_nxt.tag_lo = pwdata;
            end
            if (paddr == APB_AW'(cmo_pkg::REG_WATCH)) begin
                s_nxt.watch = pwdata;
            end
        end

        // Operation sequencer.
        case (s_r.st)
            cmo_pkg::ST_IDLE: begin
                if (issue_valid) begin
                    // R2: displacement field bits
                    // R1: address formation
                    ea = issue.base_value + {{16{issue.instr[cmo_pkg::DISP_W-1]}},
                                             issue.instr[cmo_pkg::DISP_LSB +: cmo_pkg::DISP_W]};
                    s_nxt.ea   = ea;
                    s_nxt.addr = ea;
                    // R19: operation field
                    s_nxt.op   = issue.instr[cmo_pkg::OPC_LSB +: 3];
                    // R17: cache selector
                    s_nxt.sel  = issue.instr[cmo_pkg::SEL_LSB +: 2];
                    s_nxt.exc  = cmo_pkg::exc_none;
                    s_nxt.refill = 1'b0;
                    // R10: no alignment check
                    s_nxt.st = cmo_pkg::ST_ORDER;
                    // R15: fixed watch policy
                    if (s_r.ctrl[cmo_pkg::CTRL_WATCH_BIT] && ea[31:cmo_pkg::WATCH_LSB]
                            == s_r.watch[31:cmo_pkg::WATCH_LSB]) begin
                        s_nxt.exc = cmo_pkg::watch_cause;
                        s_nxt.st  = cmo_pkg::ST_DONE;
                    // R14: kernel region check
                    end else if (s_r.ctrl[cmo_pkg::CTRL_KCHECK_BIT] && user_mode
                            && ea[cmo_pkg::KERNEL_BIT]) begin
                        s_nxt.exc = cmo_pkg::address_error_load_cause;
                        s_nxt.st  = cmo_pkg::ST_DONE;
                    // R4: index operations always translate
                    end else if (issue.instr[cmo_pkg::OPC_LSB +: 3] <= cmo_pkg::OP_STORE_TAG
                            || s_r.ctrl[cmo_pkg::CTRL_XLATE_BIT]) begin
                        s_nxt.st = cmo_pkg::ST_XLATE;
                    end
                end
            end
            cmo_pkg::ST_XLATE: begin
                if (mmu_ack) begin
                    // R7: load-type cause only
                    if (mmu_resp.refill || mmu_resp.invalid) begin
                        s_nxt.exc    = cmo_pkg::tlb_load_cause;
                        s_nxt.refill = mmu_resp.refill;
                        s_nxt.st     = cmo_pkg::ST_DONE;
                    end else begin
                        // R3: virtual address keeps indexing address operations
                        if (is_index && s_r.ctrl[cmo_pkg::CTRL_IDXPHYS_BIT]) begin
                            s_nxt.addr = mmu_resp.paddr;
                        end
                        s_nxt.st = cmo_pkg::ST_ORDER;
                    end
                end
            end
            cmo_pkg::ST_ORDER: begin
                // R16: drain earlier memory work
                if (mem_idle) begin
                    s_nxt.way = (is_index || s_r.op == cmo_pkg::OP_FILL_HWBI && !wb_cache)
                              ? way_of(s_r.addr) : '0;
                    s_nxt.st  = (s_r.op == cmo_pkg::OP_IMPL_DEP || s_r.op == 3'h7)
                              ? cmo_pkg::ST_DONE : cmo_pkg::ST_READ;
                end
            end
            cmo_pkg::ST_READ: begin
                s_nxt.st = cmo_pkg::ST_CHECK;
            end
            cmo_pkg::ST_CHECK: begin
                s_nxt.st     = cmo_pkg::ST_WRITE;
                s_nxt.bus_wr = 1'b1;
                s_nxt.bus_addr = {rd_e.tag, index_of(s_r.addr), line_offset_width'(0)};
                // R13: diagnostic tag operations skip the error check
                fault = (rd_e.par != ^{rd_e.valid, rd_e.dirty, rd_e.tag})
                     && s_r.op != cmo_pkg::OP_LOAD_TAG && s_r.op != cmo_pkg::OP_STORE_TAG;
                if (fault) begin
                    // R11: tag error is a cache error
                    s_nxt.exc = cmo_pkg::cache_error_cause;
                    s_nxt.st  = cmo_pkg::ST_DONE;
                end else if (s_r.op == cmo_pkg::OP_LOAD_TAG) begin
                    s_nxt.tag_res = '0;
                    s_nxt.tag_res[cmo_pkg::TAGW_VALID_BIT] = rd_e.valid;
                    s_nxt.tag_res[cmo_pkg::TAGW_DIRTY_BIT] = rd_e.dirty;
                    s_nxt.tag_res[cmo_pkg::TAGW_TAG_LSB +: TAG_W] = rd_e.tag;
                    s_nxt.tag_res[cmo_pkg::TAGW_PERR_BIT] =
                        rd_e.par != ^{rd_e.valid, rd_e.dirty, rd_e.tag};
                    s_nxt.st = cmo_pkg::ST_DONE;
                end else if (s_r.op == cmo_pkg::OP_STORE_TAG) begin
                    s_nxt.new_e = make_entry(s_r.tag_lo[cmo_pkg::TAGW_VALID_BIT],
                                             s_r.tag_lo[cmo_pkg::TAGW_DIRTY_BIT],
                                             s_r.tag_lo[cmo_pkg::TAGW_TAG_LSB +: TAG_W]);
                end else if (s_r.op == cmo_pkg::OP_INDEX_INV) begin
                    s_nxt.new_e = make_entry(1'b0, 1'b0, rd_e.tag);
                    if (rd_e.valid && rd_e.dirty && wb_cache) begin
                        s_nxt.st = cmo_pkg::ST_BUS;
                    end
                end else if (s_r.op == cmo_pkg::OP_FILL_HWBI && !wb_cache) begin
                    // Fill of the instruction cache from the line address.
                    s_nxt.new_e    = make_entry(1'b1, 1'b0, tag_of(s_r.addr));
                    s_nxt.bus_wr   = 1'b0;
                    s_nxt.bus_addr = {tag_of(s_r.addr), index_of(s_r.addr),
                                      line_offset_width'(0)};
                    s_nxt.st = hit ? cmo_pkg::ST_DONE : cmo_pkg::ST_BUS;
                end else if (!hit) begin
                    // Hit operations step through the ways of the set.
                    s_nxt.st = cmo_pkg::ST_DONE;
                    if (s_r.way != LAST_WAY) begin
                        s_nxt.way = s_r.way + WAY_W'(1);
                        s_nxt.st  = cmo_pkg::ST_READ;
                    end
                end else begin
                    s_nxt.new_e = make_entry(s_r.op == cmo_pkg::OP_HIT_WB, 1'b0, rd_e.tag);
                    if (s_r.op != cmo_pkg::OP_HIT_INV && rd_e.dirty && wb_cache) begin
                        s_nxt.st = cmo_pkg::ST_BUS;
                    end
                end
            end
            cmo_pkg::ST_BUS: begin
                if (bus_ack) begin
                    s_nxt.st = cmo_pkg::ST_WRITE;
                    // R20: failed transfer leaves the tag untouched
                    if (bus_err) begin
                        // R11: writeback failure
                        // R12: fill failure
                        s_nxt.exc = s_r.bus_wr ? cmo_pkg::cache_error_cause
                                               : cmo_pkg::bus_error_cause;
                        s_nxt.st  = cmo_pkg::ST_DONE;
                    end
                end
            end
            cmo_pkg::ST_WRITE: begin
                s_nxt.st = cmo_pkg::ST_DONE;
            end
            cmo_pkg::ST_DONE: begin
                // R20: precise report, one pulse per instruction
                // R8: store-type causes never produced
                // R9: no protection faults exist here
                s_nxt.rep.done       = 1'b1;
                s_nxt.rep.fault      = (s_r.exc != cmo_pkg::exc_none);
                s_nxt.rep.code       = s_r.exc;
                s_nxt.rep.tlb_refill = s_r.refill;
                s_nxt.rep.bad_addr   = s_r.ea;
                s_nxt.last_exc       = s_r.exc;
                s_nxt.count          = s_r.count + 16'h0001;
                s_nxt.st             = cmo_pkg::ST_IDLE;
            end
            default: begin
                s_nxt.st = cmo_pkg::ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r      <= '0;
            s_r.ctrl <= cmo_pkg::CTRL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // R18: selector code picks the cache region of the tag memory
    assign mem_addr = {s_r.sel, s_r.way, index_of(s_r.addr)};
    assign mem_we   = (s_r.st == cmo_pkg::ST_WRITE);
    assign rd_e     = entry_type'(mem_rdata);

    tag_store #(
        .ADDR_W (MEM_AW),
        .DATA_W (TAG_W + 3)
    ) u_tags (
        .ref_clk (ref_clk),
        .rst     (rst),
        .we      (mem_we),
        .waddr   (mem_addr),
        .wdata   (s_r.new_e),
        .raddr   (mem_addr),
        .rdata   (mem_rdata)
    );

    // Handshakes and registered data outputs.
    assign issue_ready = (s_r.st == cmo_pkg::ST_IDLE);
    assign report      = s_r.rep;
    assign mmu_req     = (s_r.st == cmo_pkg::ST_XLATE);
    assign mmu_vaddr   = s_r.ea;
    assign bus_req     = (s_r.st == cmo_pkg::ST_BUS);
    assign bus_write   = s_r.bus_wr;
    assign bus_addr    = s_r.bus_addr;
    assign prdata      = s_r.prdata;
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && !reg_ok(paddr);

endmodule

// ### logic/cmo_pkg.sv
// Shared constants and types of the cache maintenance operation unit.
// Assumes a 32-bit core, an APB register port and one core clock.
package cmo_pkg;

    // Instruction word fields.
    localparam int DISP_LSB = 0;
    localparam int DISP_W   = 16;
    localparam int SEL_LSB  = 16;
    localparam int OPC_LSB  = 18;
    localparam int BASE_LSB = 21;

    // Target cache selector codes.
    localparam logic [1:0] SEL_PRIM_INSTR = 2'h0;
    localparam logic [1:0] SEL_PRIM_DATA  = 2'h1;
    localparam logic [1:0] SEL_TERTIARY   = 2'h2;
    localparam logic [1:0] SEL_SECONDARY  = 2'h3;

    // Operation selector codes.
    localparam logic [2:0] OP_INDEX_INV  = 3'h0;
    localparam logic [2:0] OP_LOAD_TAG   = 3'h1;
    localparam logic [2:0] OP_STORE_TAG  = 3'h2;
    localparam logic [2:0] OP_IMPL_DEP   = 3'h3;
    localparam logic [2:0] OP_HIT_INV    = 3'h4;
    localparam logic [2:0] OP_FILL_HWBI  = 3'h5;
    localparam logic [2:0] OP_HIT_WB     = 3'h6;

    // Kernel region and watch compare.
    localparam int KERNEL_BIT = 31;
    localparam int WATCH_LSB  = 3;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_TAG_LO     = 8'h08;
    localparam logic [7:0] REG_TAG_RESULT = 8'h0C;
    localparam logic [7:0] REG_WATCH      = 8'h10;

    // Control bits and reset value.
    localparam int CTRL_XLATE_BIT   = 0;
    localparam int CTRL_IDXPHYS_BIT = 1;
    localparam int CTRL_KCHECK_BIT  = 2;
    localparam int CTRL_WATCH_BIT   = 3;
    localparam int CTRL_W           = 4;
    localparam logic [3:0] CTRL_RESET = 4'h1;

    // Status and tag word fields.
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_EXC_LSB   = 4;
    localparam int STAT_COUNT_LSB = 16;
    localparam int TAGW_VALID_BIT = 0;
    localparam int TAGW_DIRTY_BIT = 1;
    localparam int TAGW_TAG_LSB   = 2;
    localparam int TAGW_PERR_BIT  = 31;

    // Exception causes reported to the pipeline.
    typedef enum logic [2:0] {
        exc_none,
        tlb_load_cause,
        tlb_store_cause,
        address_error_load_cause,
        cache_error_cause,
        bus_error_cause,
        watch_cause
    } exc_code_type;

    typedef enum logic [2:0] {
        ST_IDLE, ST_XLATE, ST_ORDER, ST_READ, ST_CHECK, ST_BUS, ST_WRITE, ST_DONE
    } state_type;

    typedef struct packed {
        logic [31:0] instr;
        logic [31:0] base_value;
    } issue_type;

    typedef struct packed {
        logic [31:0] paddr;
        logic        refill;
        logic        invalid;
    } mmu_resp_type;

    typedef struct packed {
        logic         done;
        logic         fault;
        exc_code_type code;
        logic         tlb_refill;
        logic [31:0]  bad_addr;
    } report_type;

endpackage

// ### logic/tag_store.sv
// Tag memory for all four target caches, one entry per cache, way and set.
// Assumes one write and one read port; read data arrive one clock later.
`timescale 1ns/100ps
module tag_store #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 24
) (
    // Clock and reset.
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Write port.
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    // Read port.
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [DATA_W-1:0] rdata
);

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
    } state_type;

    logic [DATA_W-1:0] mem [2**ADDR_W];
    state_type         s_r;
    state_type         s_nxt;

    // Read data come from a register.
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = mem[raddr];
    end

    // Array is not reset; software initialises tags by store operations.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = s_r.rdata;

endmodule

// ### dv/cmo_chk.sv
// Checker of the unit's handshakes and exception codes, bound at the foot.
// Assumes the unit's own port names.
`timescale 1ns/100ps
module cmo_chk (
    // Watched ports of the unit.
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic                  issue_ready,
    input wire cmo_pkg::report_type   report,
    input wire logic                  mmu_req,
    input wire logic                  mmu_ack,
    input wire cmo_pkg::mmu_resp_type mmu_resp,
    input wire logic                  bus_req,
    input wire logic                  bus_ack,
    input wire logic                  bus_err,
    input wire logic                  bus_write
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Requests hold until answered and reports are single pulses.
    mmu_hold_a: assert property (mmu_req && !mmu_ack |=> mmu_req) else $error("mmu req");
    bus_hold_a: assert property (bus_req && !bus_ack |=> bus_req) else $error("bus req");
    done_pulse_a: assert property (report.done |-> issue_ready ##1 !report.done)
        else $error("done pulse");
    no_store_a: assert property (report.done |-> report.code != cmo_pkg::tlb_store_cause)
        else $error("store cause");
    tlb_load_a: assert property (mmu_ack && mmu_resp.refill
        |-> ##[1:8] report.done && report.code == cmo_pkg::tlb_load_cause) else $error("tlb");
    tlb_quiet_a: assert property (mmu_ack && mmu_resp.refill |=> !bus_req [*4])
        else $error("bus after fault");
    wb_error_a: assert property (bus_ack && bus_err && bus_write
        |-> ##[1:8] report.done && report.code == cmo_pkg::cache_error_cause) else $error("wb");
    fill_error_a: assert property (bus_ack && bus_err && !bus_write
        |-> ##[1:8] report.done && report.code == cmo_pkg::bus_error_cause) else $error("fill");
endmodule
bind cache_maintenance_op_unit cmo_chk cmo_chk_inst (.*);

// ### dv/far_side.sv
// Far side model: MMU and memory bus answering one cycle after a request.
// Assumes the bench orders translation misses and bus errors.
`timescale 1ns/100ps
module far_side (
    // Fault orders, then the unit side.
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             tlb_miss,
    input  wire logic             bus_fail,
    input  wire logic             mmu_req,
    input  wire logic [31:0]      mmu_vaddr,
    input  wire logic             bus_req,
    output logic                  mmu_ack,
    output cmo_pkg::mmu_resp_type mmu_resp,
    output logic                  bus_ack,
    output logic                  bus_err,
    output logic                  mem_idle
);
    // Acknowledges follow requests by a cycle; memory is busy just after a translation.
    always_ff @(posedge ref_clk) begin
        mmu_ack  <= !rst && mmu_req && !mmu_ack;
        bus_ack  <= !rst && bus_req && !bus_ack;
        mem_idle <= rst || !mmu_ack;
    end
    // Answer fields mean something only with the acknowledge.
    assign mmu_resp = mmu_ack ? {mmu_vaddr, tlb_miss, 1'h0} : {~mmu_vaddr, 2'h3};
    assign bus_err  = bus_ack ? bus_fail : !bus_fail;
endmodule

// ### dv/tb.sv
// Bench of the cache maintenance unit: operation table on every cache, then faults.
// Assumes the unit, its checker and the far side model.
`timescale 1ns/100ps
module tb;
    `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
        $display("Error %s expected %h seen %h", nm, e, g); end end
    typedef struct packed {logic [2:0] op; logic [15:0] disp; logic [2:0] code;} row_type;
    row_type rows [9] = '{'{3'h2, 16'hFFF0, 3'h0}, '{3'h2, 16'h07F0, 3'h0}, '{3'h1, 16'hFFF0, 3'h0},
        '{3'h4, 16'hFFF0, 3'h0}, '{3'h5, 16'h07F0, 3'h0}, '{3'h6, 16'hFFF0, 3'h0},
        '{3'h0, 16'hFFF3, 3'h0}, '{3'h3, 16'hFFF0, 3'h0}, '{3'h7, 16'hFFF0, 3'h0}};
    logic        ref_clk, rst, issue_valid, issue_ready, user_mode, mmu_req, mmu_ack, mem_idle;
    logic        bus_req, bus_write, bus_ack, bus_err, psel, penable, pwrite, pready, pslverr;
    logic        tlb_miss, bus_fail, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, mmu_vaddr, bus_addr, rd;
    cmo_pkg::issue_type    issue;
    cmo_pkg::report_type   report;
    cmo_pkg::mmu_resp_type mmu_resp;
    int          n_errors, n_checks;
    cache_maintenance_op_unit cache_maintenance_op_unit_inst (.*);
    far_side far_side_inst (.*);
    // Core clock of 10 ns.
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    // One APB transfer; read data and error land in rd and rerr.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1 && ++i < 20);
        if (i == 20) close_out(1);
        {rd, rerr} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        @(posedge ref_clk);
    endtask
    // Issues one operation and checks its report.
    task automatic do_op(input logic [2:0] op, input logic [1:0] sel, input logic [15:0] d,
                         input logic [31:0] base, input logic [2:0] code);
        int i;
        {issue_valid, issue} <= {1'h1, 6'h2F, 5'h01, op, sel, d, base};
        @(posedge ref_clk);
        issue_valid <= 1'h0;
        do @(posedge ref_clk); while (report.done !== 1'h1 && ++i < 100);
        if (i == 100) close_out(1);
        `CHK("code", code, report.code)
        `CHK("bad_addr", base + {{16{d[15]}}, d}, report.bad_addr)
        `CHK("fault", {code != 0, code == 1}, {report.fault, report.tlb_refill})
        $display("op %h sel %h done", op, sel);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic close_out(input bit hung);
        n_errors += hung;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Reset, registers, the table on each cache, then fault cases.
    initial begin
        {issue_valid, issue, user_mode, psel, penable, pwrite, paddr, pwdata} = '0;
        {rst, tlb_miss, bus_fail} = 3'h4;
        repeat (5) @(posedge ref_clk);
        rst <= 1'h0;
        apb(1'h0, cmo_pkg::REG_CTRL, 32'h0);
        `CHK("ctrl", 32'h0000_0001, rd)
        apb(1'h0, 8'hFC, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {rerr, rd})
        apb(1'h1, cmo_pkg::REG_TAG_LO, 32'h1);
        for (int s = 0; s < 4; s++)
            for (int r = 0; r < 9; r++)
                do_op(rows[r].op, s[1:0], rows[r].disp, 32'h50, rows[r].code);
        apb(1'h1, cmo_pkg::REG_TAG_LO, 32'h3);
        do_op(3'h2, 2'h1, 16'hFFF0, 32'h50, 3'h0);
        bus_fail <= 1'h1;
        do_op(3'h0, 2'h1, 16'hFFF0, 32'h50, cmo_pkg::cache_error_cause);
        do_op(3'h5, 2'h0, 16'hFFF0, 32'h50, cmo_pkg::bus_error_cause);
        {bus_fail, tlb_miss} <= 2'h1;
        do_op(3'h0, 2'h1, 16'hFFF0, 32'h50, cmo_pkg::tlb_load_cause);
        tlb_miss <= 1'h0;
        do_op(3'h1, 2'h1, 16'hFFF0, 32'h50, 3'h0);
        apb(1'h0, cmo_pkg::REG_TAG_RESULT, 32'h0);
        `CHK("dirty_kept", 2'h3, rd[1:0])
        apb(1'h1, cmo_pkg::REG_WATCH, 32'h40);
        apb(1'h1, cmo_pkg::REG_CTRL, 32'hD);
        do_op(3'h4, 2'h1, 16'h0007, 32'h40, cmo_pkg::watch_cause);
        user_mode <= 1'h1;
        do_op(3'h4, 2'h1, 16'hFFF0, 32'h8000_0050, cmo_pkg::address_error_load_cause);
        close_out(0);
    end
endmodule
